// File: include/crt_host_pkg.sv
package crt_host_pkg;
    // own register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SCROLL = 8'h04;
    localparam logic [7:0] REG_TIMING = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_CMD = 8'h10;
    // device register indices
    localparam logic [4:0] IDX_TOTAL_CHARS = 5'h00;
    localparam logic [4:0] IDX_DISP_CHARS = 5'h01;
    localparam logic [4:0] IDX_TOTAL_LINES = 5'h04;
    localparam logic [4:0] IDX_DISP_LINES = 5'h06;
    localparam logic [4:0] IDX_SCAN_MODE = 5'h08;
    localparam logic [4:0] IDX_MAX_RASTER = 5'h09;
    localparam logic [4:0] IDX_CURSOR_START = 5'h0a;
    localparam logic [4:0] IDX_SMOOTH_SCROLL = 5'h1d;
    localparam logic [4:0] IDX_SYNC_CTRL = 5'h1e;
    localparam logic [4:0] IDX_SCROLL_CTRL = 5'h1f;
    // sync_interrupt_partition_control fields
    localparam int CTL_EXT_VSYNC = 7;
    localparam int CTL_VSYNC_SEL = 6;
    localparam int CTL_VIDEO_SYNC = 2;
    // scroll_interp_control_status fields
    localparam int SC_RASTER_DOUBLE = 3;
    localparam logic [7:0] SC_RSVD_MASK = 8'h07;
    localparam int ST_FIELD = 2;
    localparam int ST_VBLANK = 1;
    localparam int ST_PEN = 0;
    // own STATUS word
    localparam int OS_REFUSED = 3;
    localparam int OS_INIT_DONE = 4;
    localparam int OS_BUSY = 5;
    localparam int OS_IRQ_SEEN = 6;
    localparam int CMD_REINIT = 0;
    localparam int CMD_POLL = 1;
    localparam logic [1:0] SCAN_INTERLACE_VIDEO = 2'h3;
    localparam logic [1:0] CURSOR_MODE_OFF = 2'h1;
    localparam int CURSOR_MODE_LSB = 5;
    // programming limits, as written values
    localparam logic [7:0] MIN_TOTAL_CHARS_W = 8'h02;
    localparam logic [7:0] MIN_TOTAL_CHARS_NONINT_W = 8'h04;
    localparam logic [7:0] MAX_TOTAL_LINES_W = 8'h7f;
    localparam logic [7:0] MIN_RASTER_IV = 8'h02;
    localparam logic [7:0] MAX_RASTER_IV = 8'h1e;
    // device bus timing
    localparam int CLK_NS = 10;
    localparam int E_PERIOD_NS = 500;
    localparam int E_HIGH_NS = 220;
    localparam int E_LOW_NS = 210;
    localparam int ADDR_HOLD_NS = 10;
    localparam int E_HIGH_CYC = (E_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int E_LOW_MIN_CYC = (E_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int E_PERIOD_CYC = (E_PERIOD_NS + CLK_NS - 1) / CLK_NS;
    localparam int E_LOW_CYC = (E_PERIOD_CYC - E_HIGH_CYC > E_LOW_MIN_CYC) ?
        E_PERIOD_CYC - E_HIGH_CYC : E_LOW_MIN_CYC;
    localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 6;
    localparam int POLL_CYCLES_DEFAULT = 1000;
endpackage

// File: include/crt_access_if.sv
`timescale 1ns/1ps
interface crt_access_if;
    logic req;
    logic rd;
    logic [4:0] idx;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic [7:0] rdata;
    modport master (output req, output rd, output idx, output wdata,
                    input busy, input done, input rdata);
    modport engine (input req, input rd, input idx, input wdata,
                    output busy, output done, output rdata);
endinterface

// File: rtl/crt_bus_engine.sv
`timescale 1ns/1ps
module crt_bus_engine
    import crt_host_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    crt_access_if.engine acc,
    output logic crt_cs_n_o,
    output logic crt_rs_o,
    output logic crt_rw_o,
    output logic crt_e_o,
    output logic [7:0] crt_data_o,
    output logic crt_data_oe_n_o,
    input wire logic [7:0] crt_data_i
);
    typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_type;
    typedef struct packed {
        phase_type phase;
        logic data_phase;
        logic rd;
        logic [7:0] wdata;
        logic [CNT_W-1:0] cnt;
        logic done;
        logic [7:0] rdata;
        logic cs_n;
        logic rs;
        logic rw;
        logic e;
        logic [7:0] dout;
        logic oe_n;
    } eng_type;

    eng_type q, n;

    // each access is two E cycles: index into address register, then data
    always_comb begin
        n = q;
        n.done = 1'b0;
        unique case (q.phase)
            PH_IDLE: begin
                if (acc.req) begin
                    n.rd = acc.rd;
                    n.wdata = acc.wdata;
                    n.data_phase = 1'b0;
                    n.cs_n = 1'b0;
                    n.rs = 1'b0;
                    n.rw = 1'b0;
                    n.dout = {3'h0, acc.idx};
                    n.oe_n = 1'b0;
                    n.cnt = CNT_W'(E_LOW_CYC - 1);
                    n.phase = PH_SETUP;
                end
            end
            PH_SETUP: begin
                n.cnt = q.cnt - 1'b1;
                if (q.cnt == '0) begin
                    n.e = 1'b1;
                    n.cnt = CNT_W'(E_HIGH_CYC - 1);
                    n.phase = PH_STROBE;
                end
            end
            PH_STROBE: begin
                n.cnt = q.cnt - 1'b1;
                if (q.cnt == '0) begin
                    n.e = 1'b0;
                    // sampled at the very end of E high, data is longest settled
                    if (q.data_phase && q.rd) begin
                        n.rdata = crt_data_i;
                    end
                    n.cnt = CNT_W'(HOLD_CYC - 1);
                    n.phase = PH_HOLD;
                end
            end
            PH_HOLD: begin
                n.cnt = q.cnt - 1'b1;
                if (q.cnt == '0) begin
                    if (!q.data_phase) begin
                        n.data_phase = 1'b1;
                        n.rs = 1'b1;
                        n.rw = q.rd;
                        n.dout = q.wdata;
                        n.oe_n = q.rd;
                        n.cnt = CNT_W'(E_LOW_CYC - 1);
                        n.phase = PH_SETUP;
                    end else begin
                        n.cs_n = 1'b1;
                        n.rw = 1'b1;
                        n.oe_n = 1'b1;
                        n.done = 1'b1;
                        n.phase = PH_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q <= '{phase: PH_IDLE, cs_n: 1'b1, rw: 1'b1, oe_n: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    assign acc.busy = (q.phase != PH_IDLE);
    assign acc.done = q.done;
    assign acc.rdata = q.rdata;
    assign crt_cs_n_o = q.cs_n;
    assign crt_rs_o = q.rs;
    assign crt_rw_o = q.rw;
    assign crt_e_o = q.e;
    assign crt_data_o = q.dout;
    assign crt_data_oe_n_o = q.oe_n;
endmodule

// File: rtl/crt_host_ctrl.sv
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module crt_host_ctrl
    import crt_host_pkg::*;
#(
    parameter int POLL_CYCLES = POLL_CYCLES_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic crt_cs_n_o,
    output logic crt_rs_o,
    output logic crt_rw_o,
    output logic crt_e_o,
    output logic [7:0] crt_data_o,
    output logic crt_data_oe_n_o,
    input wire logic [7:0] crt_data_i,
    input wire logic horizontal_sync_pin_i,
    input wire logic display_timing_out_i,
    input wire logic cursor_display_out_i,
    output logic char_clk_hold_o
);
    localparam int POLL_W = $clog2(POLL_CYCLES + 1);

    typedef enum logic [1:0] {K_CTRL, K_SCROLL, K_TIMING, K_POLL} kind_type;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] scroll;
        logic [4:0] t_idx;
        logic [7:0] t_val;
        logic pend_ctrl;
        logic pend_scroll;
        logic pend_timing;
        logic pend_poll;
        logic [7:0] total_chars;
        logic [7:0] total_lines;
        logic [1:0] scan_mode;
        logic [4:0] max_raster;
        logic cursor_off;
        logic field;
        logic vblank;
        logic pen;
        logic refused;
        logic init_done;
        logic irq_seen;
        logic req;
        logic rd;
        logic [4:0] idx;
        logic [7:0] wdata;
        logic in_flight;
        kind_type kind;
        logic [POLL_W-1:0] poll_cnt;
        logic [31:0] rd_data;
    } host_type;

    host_type q, n;
    crt_access_if acc ();

    logic tv_mode;
    logic ctrl_ok;
    logic scroll_ok;
    logic timing_ok;
    logic [4:0] w_idx;
    logic [7:0] w_val;
    logic irq_now;
    logic busy;

    // checks a raw device write against the programming limits
    function automatic logic timing_legal(input logic [4:0] idx, input logic [7:0] val,
                                          input host_type s, input logic tv);
        logic nonint;
        logic video;
        nonint = (s.scan_mode[0] == 1'b0) || tv;
        video = (s.scan_mode == SCAN_INTERLACE_VIDEO) && !tv;
        timing_legal = 1'b1;
        unique case (idx)
            IDX_TOTAL_CHARS: timing_legal = nonint ? (val >= MIN_TOTAL_CHARS_NONINT_W)
                                                   : (val >= MIN_TOTAL_CHARS_W);
            IDX_DISP_CHARS: timing_legal = (val != 8'h00) && (val <= s.total_chars);
            IDX_TOTAL_LINES: timing_legal = (val <= MAX_TOTAL_LINES_W);
            IDX_DISP_LINES: timing_legal = (val != 8'h00) && (val <= s.total_lines);
            IDX_MAX_RASTER: timing_legal = !video ||
                ((val >= MIN_RASTER_IV) && (val <= MAX_RASTER_IV));
            IDX_SMOOTH_SCROLL: timing_legal = (val < {3'h0, s.max_raster});
            IDX_SYNC_CTRL, IDX_SCROLL_CTRL: timing_legal = 1'b0;
            default: timing_legal = 1'b1;
        endcase
    endfunction

    assign tv_mode = q.ctrl[CTL_EXT_VSYNC] && q.ctrl[CTL_VIDEO_SYNC];
    assign w_idx = wdata_i[12:8];
    assign w_val = wdata_i[7:0];
    // codes 001 and 011 are never sent; doubling refused beside ext sync
    assign ctrl_ok = (wdata_i[CTL_EXT_VSYNC] || !wdata_i[CTL_VIDEO_SYNC]) &&
                     !(wdata_i[CTL_EXT_VSYNC] && q.scroll[SC_RASTER_DOUBLE]);
    assign scroll_ok = !(wdata_i[SC_RASTER_DOUBLE] &&
                         (q.ctrl[CTL_EXT_VSYNC] ||
                          q.scan_mode == SCAN_INTERLACE_VIDEO));
    assign timing_ok = !q.pend_timing && timing_legal(w_idx, w_val, q, tv_mode);
    // with the cursor off the cursor pin is the irq, valid only while blanked
    assign irq_now = q.cursor_off && !display_timing_out_i && cursor_display_out_i;
    assign busy = q.pend_ctrl || q.pend_scroll || q.pend_timing || q.pend_poll ||
                  q.in_flight;

    always_comb begin
        n = q;
        n.req = 1'b0;
        n.rd_data = '0;

        // issued before write decode so a same-cycle write re-arms its flag
        if (!q.in_flight && !acc.busy) begin
            if (q.pend_ctrl) begin
                n.pend_ctrl = 1'b0;
                n.kind = K_CTRL;
                n.idx = IDX_SYNC_CTRL;
                n.wdata = q.ctrl;
                n.rd = 1'b0;
                n.req = 1'b1;
                n.in_flight = 1'b1;
            end else if (q.pend_scroll) begin
                n.pend_scroll = 1'b0;
                n.kind = K_SCROLL;
                n.idx = IDX_SCROLL_CTRL;
                n.wdata = q.scroll & ~SC_RSVD_MASK;
                n.rd = 1'b0;
                n.req = 1'b1;
                n.in_flight = 1'b1;
            end else if (q.pend_timing) begin
                n.pend_timing = 1'b0;
                n.kind = K_TIMING;
                n.idx = q.t_idx;
                n.wdata = q.t_val;
                n.rd = 1'b0;
                n.req = 1'b1;
                n.in_flight = 1'b1;
            end else if (q.pend_poll) begin
                n.pend_poll = 1'b0;
                n.kind = K_POLL;
                n.idx = IDX_SCROLL_CTRL;
                n.wdata = 8'h00;
                n.rd = 1'b1;
                n.req = 1'b1;
                n.in_flight = 1'b1;
            end
        end

        if (wr_i) begin
            case (addr_i)
                REG_CTRL: begin
                    if (ctrl_ok) begin
                        n.ctrl = wdata_i[7:0];
                        n.pend_ctrl = 1'b1;
                    end else begin
                        n.refused = 1'b1;
                    end
                end
                REG_SCROLL: begin
                    if (scroll_ok) begin
                        n.scroll = wdata_i[7:0] & ~SC_RSVD_MASK;
                        n.pend_scroll = 1'b1;
                    end else begin
                        n.refused = 1'b1;
                    end
                end
                REG_TIMING: begin
                    if (timing_ok) begin
                        n.t_idx = w_idx;
                        n.t_val = w_val;
                        n.pend_timing = 1'b1;
                    end else begin
                        n.refused = 1'b1;
                    end
                end
                REG_CMD: begin
                    if (wdata_i[CMD_REINIT]) begin
                        n.pend_ctrl = 1'b1;
                        n.pend_scroll = 1'b1;
                        n.init_done = 1'b0;
                    end
                    if (wdata_i[CMD_POLL]) begin
                        n.pend_poll = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (rd_i) begin
            case (addr_i)
                REG_CTRL: n.rd_data = {24'h0, q.ctrl};
                REG_SCROLL: n.rd_data = {24'h0, q.scroll[7:3], q.field, q.vblank, q.pen};
                REG_TIMING: n.rd_data = {19'h0, q.t_idx, q.t_val};
                REG_STATUS: begin
                    n.rd_data = {25'h0, q.irq_seen, busy, q.init_done, q.refused,
                                 q.field, q.vblank, q.pen};
                    // read-to-clear, any set below still wins
                    n.pen = 1'b0;
                    n.refused = 1'b0;
                    n.irq_seen = 1'b0;
                end
                default: n.rd_data = '0;
            endcase
        end

        if (irq_now) begin
            n.irq_seen = 1'b1;
        end

        // periodic status poll; each device read clears its pen flag
        if (q.poll_cnt == '0) begin
            n.poll_cnt = POLL_W'(POLL_CYCLES - 1);
            n.pend_poll = 1'b1;
        end else begin
            n.poll_cnt = q.poll_cnt - 1'b1;
        end

        if (acc.done) begin
            n.in_flight = 1'b0;
            unique case (q.kind)
                K_CTRL: ;
                K_SCROLL: n.init_done = !n.pend_ctrl && !n.pend_scroll;
                K_TIMING: begin
                    unique case (q.t_idx)
                        IDX_TOTAL_CHARS: n.total_chars = q.t_val;
                        IDX_TOTAL_LINES: n.total_lines = q.t_val;
                        IDX_SCAN_MODE: n.scan_mode = q.t_val[1:0];
                        IDX_MAX_RASTER: n.max_raster = q.t_val[4:0];
                        IDX_CURSOR_START: n.cursor_off =
                            (q.t_val[CURSOR_MODE_LSB +: 2] == CURSOR_MODE_OFF);
                        default: ;
                    endcase
                end
                K_POLL: begin
                    n.vblank = acc.rdata[ST_VBLANK];
                    if (acc.rdata[ST_PEN]) begin
                        n.pen = 1'b1;
                    end
                    // field bit only trusted on the first poll inside blanking
                    if (acc.rdata[ST_VBLANK] && !q.vblank) begin
                        n.field = acc.rdata[ST_FIELD];
                    end
                end
            endcase
        end

    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            // both control registers are rewritten straight after reset
            q <= '{pend_ctrl: 1'b1, pend_scroll: 1'b1, kind: K_CTRL,
                   default: '0};
        end else begin
            q <= n;
        end
    end

    assign acc.req = q.req;
    assign acc.rd = q.rd;
    assign acc.idx = q.idx;
    assign acc.wdata = q.wdata;
    assign rdata_o = q.rd_data;
    // combinational so the clock stops in the same cycle hsync rises
    assign char_clk_hold_o = tv_mode && horizontal_sync_pin_i;

    crt_bus_engine u_engine (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .acc(acc),
        .crt_cs_n_o(crt_cs_n_o),
        .crt_rs_o(crt_rs_o),
        .crt_rw_o(crt_rw_o),
        .crt_e_o(crt_e_o),
        .crt_data_o(crt_data_o),
        .crt_data_oe_n_o(crt_data_oe_n_o),
        .crt_data_i(crt_data_i)
    );
endmodule

// File: test/crt_host_ctrl_properties.sv
`timescale 1ns/1ps
module crt_host_ctrl_checker
    import crt_host_pkg::*;
#(
    parameter int POLL_CYCLES = POLL_CYCLES_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic crt_cs_n_o,
    input wire logic crt_rs_o,
    input wire logic crt_rw_o,
    input wire logic crt_e_o,
    input wire logic [7:0] crt_data_o,
    input wire logic crt_data_oe_n_o,
    input wire logic horizontal_sync_pin_i,
    input wire logic char_clk_hold_o
);
    logic [4:0] idx_q;
    logic [7:0] ctl_q;
    logic [7:0] mr_q;
    logic [5:0] hi_q;
    logic dwr;
    assign dwr = !crt_cs_n_o && crt_rs_o && !crt_rw_o && crt_e_o;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            idx_q <= 5'h00;
            ctl_q <= 8'h00;
            mr_q <= 8'h00;
            hi_q <= 6'h00;
        end else begin
            hi_q <= crt_e_o ? hi_q + 6'h01 : 6'h00;
            if (!crt_cs_n_o && !crt_rs_o && crt_e_o) idx_q <= crt_data_o[4:0];
            if (dwr && idx_q == IDX_SYNC_CTRL) ctl_q <= crt_data_o;
            if (dwr && idx_q == IDX_MAX_RASTER) mr_q <= crt_data_o;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_hold_hsync; char_clk_hold_o |-> horizontal_sync_pin_i; endproperty
    a_hold_hsync: assert property (p_hold_hsync) else $error("hold outside hsync");
    property p_low_zero; dwr && idx_q == IDX_SCROLL_CTRL |-> crt_data_o[2:0] == 3'h0; endproperty
    a_low_zero: assert property (p_low_zero) else $error("scroll low bits set");
    property p_dbl_ext;
        dwr && idx_q == IDX_SCROLL_CTRL && crt_data_o[SC_RASTER_DOUBLE] |-> !ctl_q[CTL_EXT_VSYNC];
    endproperty
    a_dbl_ext: assert property (p_dbl_ext) else $error("doubling with ext sync");
    property p_sync_code;
        dwr && idx_q == IDX_SYNC_CTRL |-> crt_data_o[CTL_EXT_VSYNC] || !crt_data_o[CTL_VIDEO_SYNC];
    endproperty
    a_sync_code: assert property (p_sync_code) else $error("banned sync code");
    property p_tchars; dwr && idx_q == IDX_TOTAL_CHARS |-> crt_data_o >= MIN_TOTAL_CHARS_W; endproperty
    a_tchars: assert property (p_tchars) else $error("total chars too small");
    property p_tlines; dwr && idx_q == IDX_TOTAL_LINES |-> crt_data_o <= MAX_TOTAL_LINES_W; endproperty
    a_tlines: assert property (p_tlines) else $error("total lines too large");
    property p_scroll_lt; dwr && idx_q == IDX_SMOOTH_SCROLL |-> crt_data_o < mr_q; endproperty
    a_scroll_lt: assert property (p_scroll_lt) else $error("scroll not below raster");
    property p_e_width; $fell(crt_e_o) |-> hi_q == 6'(E_HIGH_CYC); endproperty
    a_e_width: assert property (p_e_width) else $error("enable width wrong");
    property p_e_stable;
        $rose(crt_e_o) |=> ($stable(crt_data_o) && $stable(crt_rs_o) && !crt_cs_n_o) [*8];
    endproperty
    a_e_stable: assert property (p_e_stable) else $error("bus moved under enable");
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_oe; crt_e_o && !crt_rw_o |-> !crt_data_oe_n_o; endproperty
    a_oe: assert property (p_oe) else $error("write without drive");
    c_dev_read: cover property ($fell(crt_e_o) && crt_rw_o);
    c_hold: cover property (char_clk_hold_o);
    c_dbl: cover property (dwr && idx_q == IDX_SCROLL_CTRL && crt_data_o[SC_RASTER_DOUBLE]);
endmodule
bind crt_host_ctrl crt_host_ctrl_checker #(.POLL_CYCLES(POLL_CYCLES)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .crt_cs_n_o(crt_cs_n_o), .crt_rs_o(crt_rs_o), .crt_rw_o(crt_rw_o), .crt_e_o(crt_e_o),
    .crt_data_o(crt_data_o), .crt_data_oe_n_o(crt_data_oe_n_o),
    .horizontal_sync_pin_i(horizontal_sync_pin_i), .char_clk_hold_o(char_clk_hold_o));

// File: test/crt_dev_model.sv
`timescale 1ns/1ps
module crt_dev_model
    import crt_host_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic rs_i,
    input wire logic rw_i,
    input wire logic e_i,
    input wire logic [7:0] data_i,
    input wire logic disp_i,
    input wire logic vblank_i,
    input wire logic field_i,
    input wire logic pen_stb_i,
    output logic [7:0] data_o,
    output logic cursor_o
);
    logic [4:0] idx_q;
    logic [7:0] ctl_q;
    logic [7:0] sc_q;
    logic [7:0] last_q;
    logic pen_q;
    logic e_q;
    logic done;
    logic st_rd;
    assign done = e_q && !e_i && !cs_n_i;
    assign st_rd = !cs_n_i && rs_i && rw_i && idx_q == IDX_SCROLL_CTRL;
    // released bus toggles so a stale sample never looks valid
    assign data_o = (st_rd && e_i) ? {sc_q[7:3], field_i, vblank_i, pen_q} : ~last_q;
    assign cursor_o = !disp_i && ((ctl_q[5] && vblank_i) || (ctl_q[4] && pen_q));
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            idx_q <= 5'h00;
            ctl_q <= 8'h00;
            sc_q <= 8'h00;
            last_q <= 8'h00;
            pen_q <= 1'b0;
            e_q <= 1'b0;
        end else begin
            e_q <= e_i;
            last_q <= data_o;
            if (done && !rs_i) idx_q <= data_i[4:0];
            if (done && rs_i && !rw_i && idx_q == IDX_SYNC_CTRL) ctl_q <= data_i;
            if (done && rs_i && !rw_i && idx_q == IDX_SCROLL_CTRL) sc_q <= data_i;
            if (pen_stb_i) pen_q <= 1'b1;
            else if (done && st_rd) pen_q <= 1'b0;
        end
    end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import crt_host_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic hsync = 1'b0;
    logic disp = 1'b1;
    logic vblank = 1'b0;
    logic field = 1'b0;
    logic pen_stb = 1'b0;
    logic [31:0] rdata;
    logic [31:0] seen;
    logic [31:0] rv;
    logic [7:0] dout;
    logic [7:0] din;
    logic cs_n, rs, rw, e, oe_n, cursor_display_out, hold;
    int error_cnt = 0;
    int compares = 0;
    always #5 ref_clk = ~ref_clk;
    crt_host_ctrl #(.POLL_CYCLES(200)) dut (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .crt_cs_n_o(cs_n),
        .crt_rs_o(rs), .crt_rw_o(rw), .crt_e_o(e), .crt_data_o(dout), .crt_data_oe_n_o(oe_n),
        .crt_data_i(din), .horizontal_sync_pin_i(hsync), .display_timing_out_i(disp),
        .cursor_display_out_i(cursor_display_out), .char_clk_hold_o(hold));
    crt_dev_model dev (.ref_clk_i(ref_clk), .rst_i(rst), .cs_n_i(cs_n), .rs_i(rs), .rw_i(rw),
        .e_i(e), .data_i(dout), .disp_i(disp), .vblank_i(vblank), .field_i(field),
        .pen_stb_i(pen_stb), .data_o(din), .cursor_o(cursor_display_out));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask
    task automatic conclude();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // status reads clear sticky bits, so everything seen while waiting is gathered
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] s;
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        seen = 32'h0;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 3000; i++) begin
            rd_reg(REG_STATUS, s);
            seen = seen | s;
            if (s[OS_BUSY] === 1'b0) return;
        end
        error_cnt++;
        conclude();
    endtask
    task automatic t_ctrl();
        logic [7:0] ok [10] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'ha4, 8'he4, 8'h13, 8'h2a, 8'h31,
            8'h08};
        check("init image", 32'h0, {dev.ctl_q, dev.sc_q});
        for (int i = 0; i < 10; i++) begin
            put(REG_CTRL, {24'h0, ok[i]});
            check("ctrl refused", 32'h0, seen[OS_REFUSED]);
            check("ctrl image", ok[i], dev.ctl_q);
            rd_reg(REG_CTRL, rv);
            check("ctrl readback", {24'h0, ok[i]}, rv);
        end
        for (int i = 0; i < 2; i++) begin
            put(REG_CTRL, i ? 32'h44 : 32'h04);
            check("bad code refused", 32'h1, seen[OS_REFUSED]);
            check("ctrl kept", 32'h08, dev.ctl_q);
        end
    endtask
    task automatic t_video();
        for (int i = 0; i < 2; i++) begin
            put(REG_CTRL, i ? 32'h80 : 32'ha4);
            @(posedge ref_clk);
            hsync <= 1'b1;
            @(posedge ref_clk);
            #1 check("clock hold", i ? 32'h0 : 32'h1, hold);
            @(posedge ref_clk);
            hsync <= 1'b0;
            @(posedge ref_clk);
            #1 check("clock hold idle", 32'h0, hold);
        end
    endtask
    task automatic t_scroll();
        put(REG_SCROLL, 32'h0f);
        check("double refused", 32'h1, seen[OS_REFUSED]);
        put(REG_CTRL, 32'h00);
        put(REG_SCROLL, 32'h0f);
        check("double image", 32'h08, dev.sc_q);
        put(REG_SCROLL, 32'hf7);
        check("select image", 32'hf0, dev.sc_q);
        rd_reg(REG_SCROLL, rv);
        check("select readback", 32'h1e, rv[7:3]);
    endtask
    task automatic t_status();
        put(REG_TIMING, {19'h0, IDX_CURSOR_START, 8'h20});
        put(REG_CTRL, 32'h20);
        @(posedge ref_clk);
        vblank <= 1'b1;
        field <= 1'b1;
        disp <= 1'b0;
        pen_stb <= 1'b1;
        @(posedge ref_clk);
        pen_stb <= 1'b0;
        put(REG_CMD, 32'h2);
        check("flags", 32'h7, seen[2:0]);
        check("irq seen", 32'h1, seen[OS_IRQ_SEEN]);
        check("pen cleared", 32'h0, dev.pen_q);
        @(posedge ref_clk);
        vblank <= 1'b0;
        disp <= 1'b1;
        put(REG_CMD, 32'h2);
        rd_reg(REG_SCROLL, rv);
        check("flags idle", 32'h0, rv[1:0]);
    endtask
    task automatic t_limits();
        logic [13:0] tab [14] = '{14'h2003, 14'h0004, 14'h2105, 14'h2100, 14'h0104, 14'h2480,
            14'h047f, 14'h0905, 14'h3d05, 14'h1d04, 14'h0803, 14'h291f, 14'h2901, 14'h0902};
        for (int i = 0; i < 14; i++) begin
            put(REG_TIMING, {19'h0, tab[i][12:0]});
            check("timing refused", tab[i][13], seen[OS_REFUSED]);
        end
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        put(REG_CMD, 32'h0);
        check("init done", 32'h1, seen[OS_INIT_DONE]);
        t_ctrl();
        t_video();
        t_scroll();
        t_status();
        t_limits();
        conclude();
    end
endmodule
